// ==== rtl/cmd_interp_pkg.sv ====
// constants, register map and state type of the parameter command interpreter
package cmd_interp_pkg;

	// instruction codes
	localparam logic [7:0] OP_AXIS_READ = 8'h06;
	localparam logic [7:0] OP_GLOBAL_WRITE = 8'h09;
	localparam logic [7:0] OP_GLOBAL_READ = 8'h0A;
	localparam logic [7:0] OP_GLOBAL_SAVE = 8'h0B;
	localparam logic [7:0] OP_GLOBAL_RELOAD = 8'h0C;

	// banks and axis range
	localparam logic [7:0] BANK_SETTINGS = 8'h00;
	localparam logic [7:0] BANK_USER = 8'h02;
	localparam logic [7:0] BANK_IRQ_CFG = 8'h03;
	localparam logic [7:0] AXIS_MAX = 8'h02;

	// reply status codes
	localparam logic [7:0] ST_OK = 8'h64;
	localparam logic [7:0] ST_BAD_CHECKSUM = 8'h01;
	localparam logic [7:0] ST_BAD_CMD = 8'h02;
	localparam logic [7:0] ST_BAD_VALUE = 8'h04;

	// register byte offsets
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_FRAME_HEAD = 12'h004;
	localparam logic [11:0] OFF_FRAME_VALUE = 12'h008;
	localparam logic [11:0] OFF_FRAME_CHECK = 12'h00C;
	localparam logic [11:0] OFF_STATUS = 12'h010;
	localparam logic [11:0] OFF_REPLY_VALUE = 12'h014;
	localparam logic [11:0] OFF_ACCUM = 12'h018;

	// field positions
	localparam int CTRL_STANDALONE_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_BOOT_BIT = 1;
	localparam int STAT_DONE_BIT = 2;
	localparam int STAT_CODE_LSB = 8;
	localparam int HEAD_TARGET_LSB = 24;
	localparam int HEAD_INSTR_LSB = 16;
	localparam int HEAD_TYPE_LSB = 8;
	localparam int HEAD_BANK_LSB = 0;

	// bank 0 setting that selects manual restore of user variables
	localparam logic [7:0] RESTORE_CFG_PARAM = 8'hFF;
	localparam int RESTORE_MANUAL_BIT = 0;

	// reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [7:0] RST_CODE = 8'h00;
	localparam logic [8:0] BOOT_LAST_SETTING = 9'h0FF;
	localparam logic [8:0] BOOT_LAST_USER = 9'h1FF;

	// storage depths
	localparam int NV_DEPTH = 512;
	localparam int LIVE_DEPTH = 1024;

	typedef enum {
		S_BOOT_CFG, S_BOOT_CFGW, S_BOOT_RD, S_BOOT_WR,
		S_IDLE, S_CHECK, S_AXIS, S_READ_WB, S_SAVE,
		S_RELOAD_RD, S_RELOAD_WB
	} state_e;

endpackage : cmd_interp_pkg

// ==== rtl/nv_store.sv ====
// non-volatile copy of bank 0 settings and bank 2 user variables
`timescale 1ns/1ns
module nv_store
	import cmd_interp_pkg::*;
(
	input wire logic hclk,
	input wire logic we,
	input wire logic [8:0] waddr,
	input wire logic [31:0] wdata,
	input wire logic [8:0] raddr,
	output logic [31:0] rdata
);

	// no reset: contents must survive hresetn, like the cells they model
	logic [31:0] cells [0:NV_DEPTH-1];

	initial begin
		for (int i = 0; i < NV_DEPTH; i++) begin
			cells[i] = RST_WORD;
		end
	end

	always_ff @(posedge hclk) begin
		if (we) begin
			cells[waddr] <= wdata;
		end
		rdata <= cells[raddr];
	end

endmodule : nv_store

// ==== rtl/cmd_interp.sv ====
// parameter command interpreter with AHB-Lite register access
//
// Summary of operation
// RULE1: code 6 reads axis parameter; type is parameter, bank field axis 0..2.
// RULE2: axis read copies the selected value into the accumulator.
// RULE3: direct mode reads leave the accumulator; standalone mode updates it.
// RULE4: code 9 writes global parameter; bank 0, 2 or 3; value is data.
// RULE5: global parameters live in banks 0 settings, 2 user, 3 interrupt.
// RULE6: a write to bank 0 is saved to non-volatile memory at once.
// RULE7: code 10 reads global parameter in bank 0, 2 or 3; value ignored.
// RULE8: global read copies the addressed parameter into the accumulator.
// RULE9: successful read replies status 100 with the value read.
// RULE10: code 11 saves a bank 2 variable; replies status 100, value 0.
// RULE11: save writes the live value of the variable to non-volatile memory.
// RULE12: after reset user variables reload unless manual restore is set.
// RULE13: reload overwrites a live user variable with its saved copy.
// RULE14: code 12 reloads a bank 2 variable; replies status 100, value 0.
// RULE15: frame is target, code, type, bank, value bytes 3..0, checksum.
// RULE16: checksum is low byte of the sum of the eight bytes before it.
`timescale 1ns/1ns
module cmd_interp
	import cmd_interp_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic ap_req,
	output logic [7:0] ap_axis,
	output logic [7:0] ap_param,
	input wire logic ap_ack,
	input wire logic [31:0] ap_value
);

	function automatic logic [7:0] frame_sum(input logic [31:0] head,
		input logic [31:0] value);
		frame_sum = head[31:24] + head[23:16] + head[15:8] + head[7:0]
			+ value[31:24] + value[23:16] + value[15:8] + value[7:0];
	endfunction : frame_sum

	////////////////////////////////////////////////////////////////////////
	// bus slave

	state_e state;
	logic dp_valid;
	logic dp_write;
	logic [11:0] dp_addr;
	logic [31:0] ctrl;
	logic [31:0] frame_head;
	logic [31:0] frame_value;
	logic [7:0] frame_check;
	logic [7:0] reply_status;
	logic [31:0] reply_value;
	logic [31:0] accum;
	logic done;

	wire addr_take = hsel && htrans[1] && hready && hsize == 3'h2;
	wire dp_wr = dp_valid && dp_write;
	wire idle = state == S_IDLE;
	wire boot = state == S_BOOT_CFG || state == S_BOOT_CFGW ||
		state == S_BOOT_RD || state == S_BOOT_WR;
	wire launch = dp_wr && dp_addr == OFF_FRAME_CHECK && idle;
	wire [31:0] status_word = {16'h0000, reply_status, 5'h00, done, boot,
		!idle};
	wire [31:0] read_mux =
		haddr == OFF_CTRL ? ctrl :
		haddr == OFF_FRAME_HEAD ? frame_head :
		haddr == OFF_FRAME_VALUE ? frame_value :
		haddr == OFF_FRAME_CHECK ? {24'h000000, frame_check} :
		haddr == OFF_STATUS ? status_word :
		haddr == OFF_REPLY_VALUE ? reply_value :
		haddr == OFF_ACCUM ? accum : RST_WORD;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= 12'h000;
			hrdata <= RST_WORD;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			dp_valid <= addr_take;
			dp_write <= hwrite;
			dp_addr <= haddr;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (addr_take && !hwrite) begin
				hrdata <= read_mux;
			end
		end
	end

	// frame registers are frozen while a command runs, so decode stays stable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= RST_WORD;
			frame_head <= RST_WORD;
			frame_value <= RST_WORD;
			frame_check <= RST_CODE;
		end else begin
			if (dp_wr && dp_addr == OFF_CTRL) begin
				ctrl <= {31'h00000000, hwdata[CTRL_STANDALONE_BIT]};
			end
			if (dp_wr && idle && dp_addr == OFF_FRAME_HEAD) begin
				frame_head <= hwdata;
			end
			if (dp_wr && idle && dp_addr == OFF_FRAME_VALUE) begin
				frame_value <= hwdata;
			end
			if (launch) begin
				frame_check <= hwdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// decode

	// head byte order follows the wire order of the frame, see RULE15
	wire [7:0] cmd_instr = frame_head[HEAD_INSTR_LSB +: 8];
	wire [7:0] cmd_type = frame_head[HEAD_TYPE_LSB +: 8];
	wire [7:0] cmd_bank = frame_head[HEAD_BANK_LSB +: 8];
	wire [31:0] cmd_value = frame_value;
	wire sum_ok = frame_sum(frame_head, frame_value) == frame_check; // see RULE16
	wire bank_ok = cmd_bank == BANK_SETTINGS || cmd_bank == BANK_USER ||
		cmd_bank == BANK_IRQ_CFG; // see RULE5
	wire user_bank = cmd_bank == BANK_USER;
	wire check_ok = state == S_CHECK && sum_ok;
	wire do_write = check_ok && cmd_instr == OP_GLOBAL_WRITE && bank_ok; // see RULE4
	wire standalone = ctrl[CTRL_STANDALONE_BIT];

	////////////////////////////////////////////////////////////////////////
	// storage

	logic [31:0] live [0:LIVE_DEPTH-1];
	logic [31:0] live_rdata;
	logic [31:0] nv_rdata;
	logic [8:0] boot_idx;
	logic boot_manual;

	// live index is {bank[1:0], type}; bank 1 slots exist but are never used
	wire [9:0] live_raddr = {cmd_bank[1:0], cmd_type};
	wire [9:0] boot_live = {boot_idx[8], 1'b0, boot_idx[7:0]};
	wire live_we = do_write || state == S_RELOAD_WB || state == S_BOOT_WR;
	wire [9:0] live_waddr = state == S_BOOT_WR ? boot_live : live_raddr;
	wire [31:0] live_wdata = do_write ? cmd_value : nv_rdata;
	wire nv_we = (do_write && cmd_bank == BANK_SETTINGS) ||
		state == S_SAVE; // see RULE6 see RULE11
	wire [8:0] nv_waddr = {state == S_SAVE, cmd_type};
	wire [31:0] nv_wdata = state == S_SAVE ? live_rdata : cmd_value;
	wire [8:0] nv_raddr = state == S_BOOT_CFG ? {1'b0, RESTORE_CFG_PARAM} :
		boot ? boot_idx : {1'b1, cmd_type};

	always_ff @(posedge hclk) begin
		if (live_we) begin
			live[live_waddr] <= live_wdata; // see RULE13
		end
		live_rdata <= live[live_raddr];
	end

	nv_store u_nv (
		.hclk(hclk),
		.we(nv_we),
		.waddr(nv_waddr),
		.wdata(nv_wdata),
		.raddr(nv_raddr),
		.rdata(nv_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencer

	state_e next_state;
	wire boot_end = boot_idx == BOOT_LAST_USER ||
		(boot_idx == BOOT_LAST_SETTING && boot_manual); // see RULE12

	always_comb begin
		next_state = state;
		unique case (state)
			S_BOOT_CFG: next_state = S_BOOT_CFGW;
			S_BOOT_CFGW: next_state = S_BOOT_RD;
			S_BOOT_RD: next_state = S_BOOT_WR;
			S_BOOT_WR: next_state = boot_end ? S_IDLE : S_BOOT_RD;
			S_IDLE: next_state = launch ? S_CHECK : S_IDLE;
			S_CHECK: begin
				next_state = S_IDLE;
				if (sum_ok) begin
					unique case (cmd_instr)
						OP_AXIS_READ: if (cmd_bank <= AXIS_MAX) begin
							next_state = S_AXIS;
						end
						OP_GLOBAL_READ: if (bank_ok) begin
							next_state = S_READ_WB;
						end
						OP_GLOBAL_SAVE: if (user_bank) begin
							next_state = S_SAVE;
						end
						OP_GLOBAL_RELOAD: if (user_bank) begin
							next_state = S_RELOAD_RD;
						end
						default: next_state = S_IDLE;
					endcase
				end
			end
			S_AXIS: next_state = ap_ack ? S_IDLE : S_AXIS;
			S_READ_WB: next_state = S_IDLE;
			S_SAVE: next_state = S_IDLE;
			S_RELOAD_RD: next_state = S_RELOAD_WB;
			S_RELOAD_WB: next_state = S_IDLE;
		endcase
	end

	// status of a command that ends in the check cycle
	wire known_op = cmd_instr == OP_AXIS_READ || cmd_instr == OP_GLOBAL_WRITE ||
		cmd_instr == OP_GLOBAL_READ || cmd_instr == OP_GLOBAL_SAVE ||
		cmd_instr == OP_GLOBAL_RELOAD;
	wire [7:0] check_code = !sum_ok ? ST_BAD_CHECKSUM :
		!known_op ? ST_BAD_CMD :
		do_write ? ST_OK : ST_BAD_VALUE;
	wire finish = next_state == S_IDLE && !idle && !boot;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= S_BOOT_CFG;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			boot_idx <= 9'h000;
			boot_manual <= 1'b0;
		end else begin
			if (state == S_BOOT_CFGW) begin
				boot_manual <= nv_rdata[RESTORE_MANUAL_BIT];
			end
			if (state == S_BOOT_WR) begin
				boot_idx <= boot_idx + 9'h001;
			end
		end
	end

	// axis parameter fetch: request held until the owner acknowledges
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_req <= 1'b0;
			ap_axis <= 8'h00;
			ap_param <= 8'h00;
		end else if (next_state == S_AXIS && state == S_CHECK) begin
			ap_req <= 1'b1; // see RULE1
			ap_axis <= cmd_bank;
			ap_param <= cmd_type;
		end else if (state == S_AXIS && ap_ack) begin
			ap_req <= 1'b0;
		end
	end

	// done is sticky; only a new launch clears it and none lands while busy
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reply_status <= RST_CODE;
			reply_value <= RST_WORD;
			accum <= RST_WORD;
			done <= 1'b0;
		end else begin
			if (launch) begin
				done <= 1'b0;
			end
			if (finish) begin
				done <= 1'b1;
			end
			unique case (state)
				S_CHECK: if (finish) begin
					reply_status <= check_code;
					reply_value <= RST_WORD;
				end
				S_AXIS: if (ap_ack) begin
					reply_status <= ST_OK; // see RULE9
					reply_value <= ap_value;
					if (standalone) begin
						accum <= ap_value; // see RULE2 see RULE3
					end
				end
				S_READ_WB: begin
					reply_status <= ST_OK; // see RULE9 see RULE7
					reply_value <= live_rdata;
					if (standalone) begin
						accum <= live_rdata; // see RULE8 see RULE3
					end
				end
				S_SAVE, S_RELOAD_WB: begin
					reply_status <= ST_OK; // see RULE10 see RULE14
					reply_value <= RST_WORD;
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_axis_direct: assert property ( // see RULE3
		state == S_AXIS && ap_ack && !standalone |=> accum == $past(accum))
		else $error("axis read in direct mode changed accumulator");

	a_axis_accum: assert property ( // see RULE2
		state == S_AXIS && ap_ack && standalone |=>
		accum == $past(ap_value) && reply_status == ST_OK)
		else $error("axis read did not load accumulator");

	a_read_reply: assert property ( // see RULE9
		state == S_CHECK && sum_ok && cmd_instr == OP_GLOBAL_READ && bank_ok
		##1 1'b1 |=> reply_status == ST_OK &&
		reply_value == live[$past(live_raddr, 2)] && done)
		else $error("global read reply wrong");

	a_bank0_save: assert property ( // see RULE6
		do_write && cmd_bank == BANK_SETTINGS |=>
		u_nv.cells[{1'b0, $past(cmd_type)}] == $past(cmd_value))
		else $error("bank 0 write not saved");

	a_save_cell: assert property ( // see RULE11
		state == S_CHECK && sum_ok && cmd_instr == OP_GLOBAL_SAVE &&
		user_bank |-> ##2 u_nv.cells[{1'b1, cmd_type}] == $past(live_rdata))
		else $error("saved value differs from live value");

	a_reload_cell: assert property ( // see RULE13
		state == S_RELOAD_RD |-> ##2 live[live_raddr] == $past(nv_rdata))
		else $error("reload did not restore variable");

	a_bad_sum: assert property ( // see RULE16
		state == S_CHECK && !sum_ok |=> state == S_IDLE &&
		reply_status == ST_BAD_CHECKSUM && $rose(done))
		else $error("bad checksum not reported");

	a_save_bank: assert property ( // see RULE10
		state == S_CHECK && cmd_instr == OP_GLOBAL_SAVE && !user_bank
		|=> state == S_IDLE && !nv_we && reply_status != ST_OK && done)
		else $error("save accepted outside bank 2");

	a_axis_range: assert property ( // see RULE1
		$rose(ap_req) |-> ap_axis <= AXIS_MAX && state == S_AXIS)
		else $error("axis request out of range");

	a_write_bank: assert property ( // see RULE4
		check_ok && cmd_instr == OP_GLOBAL_WRITE && !bank_ok |-> !live_we
		##1 reply_status == ST_BAD_VALUE)
		else $error("write to invalid bank accepted");

	c_global_read: cover property (state == S_READ_WB);
	c_axis_read: cover property (state == S_AXIS && ap_ack);
	c_reload: cover property (state == S_RELOAD_WB);
	c_boot_full: cover property (state == S_BOOT_WR && boot_idx == BOOT_LAST_USER);

endmodule : cmd_interp

// ==== bench/axis_source.sv ====
// axis logic model that answers parameter requests after a set delay
`timescale 1ns/1ns
module axis_source (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [3:0] lat,
	input wire logic ap_req,
	input wire logic [7:0] ap_axis,
	input wire logic [7:0] ap_param,
	output logic ap_ack,
	output logic [31:0] ap_value
);
	logic [3:0] wait_cnt;
	logic fire;
	assign fire = ap_req && !ap_ack && (wait_cnt >= lat);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_cnt <= 4'h0;
			ap_ack <= 1'b0;
			ap_value <= 32'h0;
		end else begin
			ap_ack <= fire;
			wait_cnt <= (ap_req && !fire && !ap_ack) ? wait_cnt + 4'h1 : 4'h0;
			// value only valid with ack; toggles otherwise so no stale match
			ap_value <= fire ? {ap_axis, ap_param, 16'h5AC3} : ~ap_value;
		end
	end
endmodule : axis_source

// ==== bench/tb_parameter_command_interpreter.sv ====
// self-checking bench of the parameter command interpreter
`timescale 1ns/1ns
module tb_parameter_command_interpreter
	import cmd_interp_pkg::*;
;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [3:0] lat = 4'h0;
	logic [31:0] hrdata, ap_value, q;
	logic hreadyout, hresp, ap_req, ap_ack;
	logic [7:0] ap_axis, ap_param;
	int error_cnt = 0;
	int n_checks = 0;

	always #2 hclk = ~hclk;

	cmd_interp cmd_interp_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ap_req(ap_req),
		.ap_axis(ap_axis), .ap_param(ap_param), .ap_ack(ap_ack),
		.ap_value(ap_value));
	axis_source axis_source_inst (.hclk(hclk), .hresetn(hresetn), .lat(lat),
		.ap_req(ap_req), .ap_axis(ap_axis), .ap_param(ap_param),
		.ap_ack(ap_ack), .ap_value(ap_value));

	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one single word transfer; read data taken at the end of the data phase
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask : bus

	task automatic wait_boot;
		int i;
		q = 32'hFFFF_FFFF;
		for (i = 0; i < 2000 && q[1:0] !== 2'h0; i++) begin
			bus(1'b0, OFF_STATUS, 32'h0, q);
		end
		chk({30'h0, q[1:0]}, 32'h0);
	endtask : wait_boot

	// sends a frame, bad flips checksum bits, then polls until done
	task automatic run(input logic [7:0] ins, input logic [7:0] ty,
		input logic [7:0] bk, input logic [31:0] v, input logic [31:0] bad,
		input logic [7:0] es, input logic [31:0] ev);
		logic [31:0] h;
		logic [7:0] sum;
		int i;
		h = {8'h01, ins, ty, bk};
		sum = 8'h00;
		for (i = 0; i < 4; i++) begin
			sum = sum + h[8*i +: 8] + v[8*i +: 8];
		end
		bus(1'b1, OFF_FRAME_HEAD, h, q);
		bus(1'b1, OFF_FRAME_VALUE, v, q);
		bus(1'b1, OFF_FRAME_CHECK, {24'h0, sum ^ bad[7:0]}, q);
		q = 32'h0;
		for (i = 0; i < 100 && (q[2] !== 1'b1 || q[0] !== 1'b0); i++) begin
			bus(1'b0, OFF_STATUS, 32'h0, q);
		end
		chk({24'h0, q[15:8]}, {24'h0, es});
		if (es == ST_OK) begin
			bus(1'b0, OFF_REPLY_VALUE, 32'h0, q);
			chk(q, ev);
		end
	endtask : run

	task automatic accum_is(input logic [31:0] ev);
		bus(1'b0, OFF_ACCUM, 32'h0, q);
		chk(q, ev);
	endtask : accum_is

	////////////////////////////////////////////////////////////////////////
	task automatic t_boot;
		bus(1'b0, OFF_STATUS, 32'h0, q);
		chk({31'h0, q[STAT_BOOT_BIT]}, 32'h1);
		bus(1'b1, 12'h0FC, 32'hFFFF_FFFF, q);
		bus(1'b0, 12'h0FC, 32'h0, q);
		chk(q, 32'h0);
		wait_boot();
	endtask : t_boot

	task automatic t_direct;
		run(OP_GLOBAL_WRITE, 8'h2A, BANK_USER, 32'h1234_5678, 0, ST_OK,
			0);
		run(OP_GLOBAL_READ, 8'h2A, BANK_USER, 32'hFFFF_0000, 0, ST_OK,
			32'h1234_5678);
		accum_is(32'h0);
		run(OP_GLOBAL_WRITE, 8'h2A, BANK_IRQ_CFG, 32'hA5A5_0003, 0, ST_OK,
			0);
		run(OP_GLOBAL_READ, 8'h2A, BANK_IRQ_CFG, 0, 0, ST_OK,
			32'hA5A5_0003);
		run(OP_GLOBAL_READ, 8'h2A, BANK_SETTINGS, 0, 0, ST_OK, 0);
	endtask : t_direct

	task automatic t_standalone;
		bus(1'b1, OFF_CTRL, 32'h1, q);
		run(OP_GLOBAL_READ, 8'h2A, BANK_USER, 0, 0, ST_OK,
			32'h1234_5678);
		accum_is(32'h1234_5678);
		lat <= 4'h0;
		run(OP_AXIS_READ, 8'h01, 8'h00, 0, 0, ST_OK, 32'h0001_5AC3);
		accum_is(32'h0001_5AC3);
		lat <= 4'h9;
		run(OP_AXIS_READ, 8'hC4, AXIS_MAX, 32'h7, 0, ST_OK,
			32'h02C4_5AC3);
		run(OP_AXIS_READ, 8'h01, 8'h03, 0, 0, ST_BAD_VALUE, 0);
		accum_is(32'h02C4_5AC3);
		bus(1'b1, OFF_CTRL, 32'h0, q);
		run(OP_AXIS_READ, 8'h05, 8'h01, 0, 0, ST_OK, 32'h0105_5AC3);
		accum_is(32'h02C4_5AC3);
	endtask : t_standalone

	task automatic t_errors;
		run(OP_GLOBAL_WRITE, 8'h2A, BANK_USER, 0, 32'h01, ST_BAD_CHECKSUM,
			0);
		run(OP_GLOBAL_READ, 8'h2A, BANK_USER, 0, 0, ST_OK,
			32'h1234_5678);
		run(8'h07, 8'h00, BANK_USER, 0, 0, ST_BAD_CMD, 0);
		run(OP_GLOBAL_WRITE, 8'h00, 8'h01, 0, 0, ST_BAD_VALUE, 0);
		run(OP_GLOBAL_SAVE, 8'h2A, BANK_SETTINGS, 0, 0, ST_BAD_VALUE,
			0);
	endtask : t_errors

	task automatic t_save;
		run(OP_GLOBAL_WRITE, 8'h05, BANK_USER, 32'hCAFE_0001, 0, ST_OK,
			0);
		run(OP_GLOBAL_SAVE, 8'h05, BANK_USER, 32'h77, 0, ST_OK, 0);
		run(OP_GLOBAL_WRITE, 8'h05, BANK_USER, 32'h0BAD_0002, 0, ST_OK,
			0);
		run(OP_GLOBAL_RELOAD, 8'h05, BANK_USER, 32'h9, 0, ST_OK, 0);
		run(OP_GLOBAL_READ, 8'h05, BANK_USER, 0, 0, ST_OK,
			32'hCAFE_0001);
	endtask : t_save

	// mid-run reset; the saved copies must outlive it
	task automatic pulse_reset;
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		wait_boot();
	endtask : pulse_reset

	// bank 0 survives reset without a save; saved user values come back
	task automatic t_reboot;
		run(OP_GLOBAL_WRITE, 8'h10, BANK_SETTINGS, 32'h0000_00C3, 0, ST_OK,
			0);
		run(OP_GLOBAL_WRITE, 8'h07, BANK_USER, 32'h0000_D00D, 0, ST_OK,
			0);
		run(OP_GLOBAL_SAVE, 8'h07, BANK_USER, 0, 0, ST_OK, 0);
		run(OP_GLOBAL_WRITE, 8'h07, BANK_USER, 32'h0000_EEEE, 0, ST_OK,
			0);
		pulse_reset();
		run(OP_GLOBAL_READ, 8'h10, BANK_SETTINGS, 0, 0, ST_OK, 32'hC3);
		run(OP_GLOBAL_READ, 8'h07, BANK_USER, 0, 0, ST_OK, 32'hD00D);
		run(OP_GLOBAL_READ, 8'h2A, BANK_USER, 0, 0, ST_OK, 32'h0);
	endtask : t_reboot

	// manual restore: a reset leaves user variables as they were
	task automatic t_manual;
		run(OP_GLOBAL_WRITE, RESTORE_CFG_PARAM, BANK_SETTINGS, 32'h1, 0, ST_OK,
			0);
		run(OP_GLOBAL_WRITE, 8'h07, BANK_USER, 32'h1111, 0, ST_OK, 0);
		pulse_reset();
		run(OP_GLOBAL_READ, 8'h07, BANK_USER, 0, 0, ST_OK, 32'h1111);
		run(OP_GLOBAL_RELOAD, 8'h07, BANK_USER, 0, 0, ST_OK, 0);
		run(OP_GLOBAL_READ, 8'h07, BANK_USER, 0, 0, ST_OK, 32'hD00D);
	endtask : t_manual

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_boot();
		t_direct();
		t_standalone();
		t_errors();
		t_save();
		t_reboot();
		t_manual();
		report_and_stop();
	end

	// three boots and a few dozen commands stay far below this span
	initial begin
		#80000;
		error_cnt++;
		report_and_stop();
	end
endmodule : tb_parameter_command_interpreter
